// [common/ssd_defines.svh]
// Holds offsets, field positions, reset values and timing figures of the sensor diagnostics.
// Assumes a single 10 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSD_OFS_CTRL 4'h0
`define SSD_OFS_STATUS 4'h4
`define SSD_OFS_IRQ_STAT 4'h8
`define SSD_OFS_IRQ_MASK 4'hC

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SSD_CTRL_RUN 0
`define SSD_CTRL_RST 1'h1
`define SSD_MASK_RST 4'h0
`define SSD_EV_FAULT 0
`define SSD_EV_SAFE_OFF 1
`define SSD_EV_LIMIT 2
`define SSD_EV_CLEAR 3
`define SSD_NUM_EV 4
`define SSD_BRESP_OK 2'h0
`define SSD_BRESP_ERR 2'h2

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define SSD_CLK_HZ 10000000
`define SSD_DIAG_DLY_S 10
`define SSD_SAFE_DLY_S 60
`define SSD_LIMIT_HZ 2
`define SSD_ANALYSE_MS 1000
`define SSD_FLASH_MS 200
`define SSD_GAP_MS 1000
`define SSD_DIAG_CYC (`SSD_DIAG_DLY_S * `SSD_CLK_HZ)
`define SSD_SAFE_CYC (`SSD_SAFE_DLY_S * `SSD_CLK_HZ)
`define SSD_LIMIT_CYC (`SSD_CLK_HZ / (2 * `SSD_LIMIT_HZ))
`define SSD_ANALYSE_CYC (`SSD_ANALYSE_MS * (`SSD_CLK_HZ / 1000))
`define SSD_FLASH_CYC (`SSD_FLASH_MS * (`SSD_CLK_HZ / 1000))
`define SSD_GAP_CYC (`SSD_GAP_MS * (`SSD_CLK_HZ / 1000))

`endif

// [common/ssd_pkg.sv]
// Holds the types shared by the sensor diagnostics block.
// Assumes ssd_defines.svh sits on the include path.
`include "ssd_defines.svh"

package ssd_pkg;

   // ----------------------------------------
   // Bus bundles
   // ----------------------------------------
   // AXI4-Lite signals driven by the master.
   typedef struct packed {
      logic awvalid;
      logic [3:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [3:0] araddr;
      logic rready;
   } ssd_axi_req_t;

   // AXI4-Lite signals driven by this slave.
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ssd_axi_rsp_t;

   // ----------------------------------------
   // Sensor bundles
   // ----------------------------------------
   // Fault detections reported by the sensing front end.
   typedef struct packed {
      logic outAErr;
      logic outBErr;
      logic crossWire;
      logic wireBreak;
      logic extVoltage;
      logic overTemp;
      logic codingErr;
      logic internalErr;
   } ssd_faults_t;

   // Indicator lamp drives.
   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } ssd_led_t;

   // Fault sequencer states.
   typedef enum logic [1:0] {
      ST_OK = 2'b00,
      ST_ANALYSE = 2'b01,
      ST_CODE = 2'b10,
      ST_HARD = 2'b11
   } ssd_state_t;

endpackage

// [core/ssd_core.sv]
// Holds the status and fault sequencing logic of the non-contact safety sensor.
// Assumes inputs synchronous to mclk and an AXI4-Lite master on the register port.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`include "ssd_defines.svh"

// Behaviour
// - Ready, no actuator: green, outputs low.
// - Actuator in range: yellow, safety outputs on.
// - Limit range: yellow flashes, outputs stay on.
// - Coding, output, internal errors shown red.
// - Steady red analysis, then red flash code.
// - Codes: A1, B2, cross3, temp4, coding5.
// - Warning fault drops outputs after one minute.
// - Warning fault: diag off 10s, outputs 1min.
// - Diagnostic high while actuated in normal range.
// - Limit range pulses diagnostic at 2 Hz.
// - Active fault drives diagnostic low after the 10s delay.
// - Outputs feed next sensor inputs, sixteen max.
// - Cable cross, break, external voltage are faults.
module ssd_core #(
   parameter int unsigned DIAG_CYC = `SSD_DIAG_CYC,
   parameter int unsigned SAFE_CYC = `SSD_SAFE_CYC,
   parameter int unsigned LIMIT_CYC = `SSD_LIMIT_CYC,
   parameter int unsigned ANALYSE_CYC = `SSD_ANALYSE_CYC,
   parameter int unsigned FLASH_CYC = `SSD_FLASH_CYC,
   parameter int unsigned GAP_CYC = `SSD_GAP_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire ssd_pkg::ssd_axi_req_t axiReq,
   output ssd_pkg::ssd_axi_rsp_t axiRsp,
   input wire logic actPresent,
   input wire logic actLimit,
   input wire ssd_pkg::ssd_faults_t faults,
   input wire logic safetyInA,
   input wire logic safetyInB,
   output logic safetyOutA,
   output logic safetyOutB,
   output logic diagOut,
   output ssd_pkg::ssd_led_t led,
   output logic irq
);
   import ssd_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   ssd_state_t state_q; // Fault sequencer state.
   logic [31:0] faultCnt_q; // Cycles since the present fault began, saturating.
   logic [31:0] limCnt_q; // Half-period counter of the 2 Hz blink.
   logic blink_q; // Shared 2 Hz square wave.
   logic [31:0] flashCnt_q; // Timer inside one flash slot or gap.
   logic [2:0] pulseNo_q; // Flash pulses already given in this burst.
   logic flashOn_q; // Red lamp phase of the flash code.
   logic inGap_q; // High during the pause between bursts.
   logic [2:0] code; // Flash count for the present warning fault.
   logic warnFault; // Any warning-class fault present.
   logic hardFault; // Internal sensor failure present.
   logic safeEn; // Both safety outputs allowed on.
   logic diagD; // Next value of the diagnostic output.
   ssd_led_t ledD; // Next lamp pattern.
   logic run_q; // Software run enable.
   logic [`SSD_NUM_EV-1:0] irqStat_q; // Sticky event flags.
   logic [`SSD_NUM_EV-1:0] irqMask_q; // Interrupt mask.
   logic [`SSD_NUM_EV-1:0] events; // One-cycle event pulses.
   logic faultPrev_q; // Fault level one cycle ago.
   logic safePrev_q; // Safety enable one cycle ago.
   logic limPrev_q; // Limit warning one cycle ago.
   logic [3:0] awAddr_q; // Captured write address.
   logic awHeld_q; // Write address taken, awaiting data.
   logic [31:0] wData_q; // Captured write data.
   logic [3:0] wStrb_q; // Captured byte enables.
   logic wHeld_q; // Write data taken, awaiting address.
   logic bValid_q; // Write response pending.
   logic [1:0] bResp_q; // Write response code.
   logic rValid_q; // Read response pending.
   logic [31:0] rData_q; // Read data.
   logic [1:0] rResp_q; // Read response code.
   logic arTake; // Read address accepted this cycle.
   logic statRead; // Accepted read of the sticky flags.
   logic wrDo; // Both halves of a write now held.

   // ----------------------------------------
   // Fault classification
   // ----------------------------------------
   // Wire break and external voltage count as output faults; lowest code wins.
   always_comb
   begin
      warnFault = faults.outAErr | faults.outBErr | faults.crossWire | faults.wireBreak
         | faults.extVoltage | faults.overTemp | faults.codingErr;
      hardFault = faults.internalErr;
      if (faults.outAErr | faults.wireBreak)
         code = 3'h1;
      else if (faults.outBErr | faults.extVoltage)
         code = 3'h2;
      else if (faults.crossWire)
         code = 3'h3;
      else if (faults.overTemp)
         code = 3'h4;
      else
         code = 3'h5;
   end

   // ----------------------------------------
   // Fault sequencer
   // ----------------------------------------
   // Moves from steady red analysis to the flash code, or to hard failure.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_OK;
      end
      else
      begin
         case (state_q)
            ST_OK:
            begin
               if (hardFault)
                  state_q <= ST_HARD;
               else if (warnFault)
                  state_q <= ST_ANALYSE;
            end
            ST_ANALYSE:
            begin
               if (hardFault)
                  state_q <= ST_HARD;
               else if (!warnFault)
                  state_q <= ST_OK;
               else if (faultCnt_q >= ANALYSE_CYC - 1)
                  state_q <= ST_CODE;
            end
            ST_CODE:
            begin
               if (hardFault)
                  state_q <= ST_HARD;
               else if (!warnFault)
                  state_q <= ST_OK;
            end
            default:
            begin
               if (!hardFault)
                  state_q <= warnFault ? ST_ANALYSE : ST_OK;
            end
         endcase
      end
   end

   // Counts the time the fault has stood without a break.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         faultCnt_q <= 32'h0;
      else if (!(warnFault | hardFault))
         faultCnt_q <= 32'h0;
      else if (faultCnt_q != 32'hFFFFFFFF)
         faultCnt_q <= faultCnt_q + 32'h1;
   end

   // ----------------------------------------
   // Blink and flash timing
   // ----------------------------------------
   // Free-running 2 Hz square wave for the limit-range indication.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         limCnt_q <= 32'h0;
         blink_q <= 1'b1;
      end
      else if (limCnt_q >= LIMIT_CYC - 1)
      begin
         limCnt_q <= 32'h0;
         blink_q <= ~blink_q;
      end
      else
      begin
         limCnt_q <= limCnt_q + 32'h1;
      end
   end

   // Gives code pulses of red, then a pause, repeated while in ST_CODE.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         flashCnt_q <= 32'h0;
         pulseNo_q <= 3'h0;
         flashOn_q <= 1'b0;
         inGap_q <= 1'b0;
      end
      else if (state_q != ST_CODE)
      begin
         // Each burst starts fresh with a lit pulse.
         flashCnt_q <= 32'h0;
         pulseNo_q <= 3'h0;
         flashOn_q <= 1'b1;
         inGap_q <= 1'b0;
      end
      else if (inGap_q)
      begin
         if (flashCnt_q >= GAP_CYC - 1)
         begin
            flashCnt_q <= 32'h0;
            inGap_q <= 1'b0;
            flashOn_q <= 1'b1;
         end
         else
         begin
            flashCnt_q <= flashCnt_q + 32'h1;
         end
      end
      else if (flashCnt_q >= FLASH_CYC - 1)
      begin
         flashCnt_q <= 32'h0;
         if (flashOn_q)
         begin
            flashOn_q <= 1'b0;
            pulseNo_q <= pulseNo_q + 3'h1;
         end
         else if (pulseNo_q >= code)
         begin
            pulseNo_q <= 3'h0;
            inGap_q <= 1'b1;
         end
         else
         begin
            flashOn_q <= 1'b1;
         end
      end
      else
      begin
         flashCnt_q <= flashCnt_q + 32'h1;
      end
   end

   // ----------------------------------------
   // Output decisions
   // ----------------------------------------
   // Works out safety enable, diagnostic level and lamps.
   always_comb
   begin
      safeEn = run_q & actPresent & safetyInA & safetyInB;
      if (hardFault)
         safeEn = 1'b0;
      else if (warnFault && faultCnt_q >= SAFE_CYC)
         safeEn = 1'b0;
      if (warnFault | hardFault)
         diagD = actPresent & (faultCnt_q < DIAG_CYC);
      else if (actPresent & actLimit)
         diagD = blink_q;
      else
         diagD = actPresent;
      ledD = '0;
      if (state_q == ST_CODE)
         ledD.red = flashOn_q & ~inGap_q;
      else if (state_q != ST_OK || warnFault || hardFault)
         ledD.red = 1'b1;
      else if (actPresent)
         ledD.yellow = actLimit ? blink_q : 1'b1;
      else
         ledD.green = 1'b1;
   end

   // Registers the pin outputs; both safety outputs share one enable.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         safetyOutA <= 1'b0;
         safetyOutB <= 1'b0;
         diagOut <= 1'b0;
         led <= '0;
      end
      else
      begin
         safetyOutA <= safeEn;
         safetyOutB <= safeEn;
         diagOut <= diagD;
         led <= ledD;
      end
   end

   // ----------------------------------------
   // Events and interrupt
   // ----------------------------------------
   // Edge detectors for fault start, safety drop, limit onset and fault end.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         faultPrev_q <= 1'b0;
         safePrev_q <= 1'b0;
         limPrev_q <= 1'b0;
      end
      else
      begin
         faultPrev_q <= warnFault | hardFault;
         safePrev_q <= safeEn;
         limPrev_q <= actPresent & actLimit;
      end
   end

   assign events[`SSD_EV_FAULT] = (warnFault | hardFault) & ~faultPrev_q;
   assign events[`SSD_EV_SAFE_OFF] = safePrev_q & ~safeEn;
   assign events[`SSD_EV_LIMIT] = actPresent & actLimit & ~limPrev_q;
   assign events[`SSD_EV_CLEAR] = faultPrev_q & ~(warnFault | hardFault);

   // Sticky flags clear on read; a new event in that cycle still sets.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqStat_q <= '0;
      end
      else
      begin
         irqStat_q <= (statRead ? '0 : irqStat_q) | events;
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   assign arTake = axiReq.arvalid & ~rValid_q;
   assign statRead = arTake & (axiReq.araddr == `SSD_OFS_IRQ_STAT);
   assign wrDo = awHeld_q & wHeld_q & ~bValid_q;

   // Takes address and data in either order, answers one cycle after both.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 4'h0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= `SSD_BRESP_OK;
      end
      else
      begin
         if (axiReq.awvalid && !awHeld_q)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= axiReq.awaddr;
         end
         if (axiReq.wvalid && !wHeld_q)
         begin
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata;
            wStrb_q <= axiReq.wstrb;
         end
         if (wrDo)
         begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b1;
            // Every aligned word of the four-word map is a register.
            if (awAddr_q[1:0] == 2'h0)
               bResp_q <= `SSD_BRESP_OK;
            else
               bResp_q <= `SSD_BRESP_ERR;
         end
         else if (bValid_q && axiReq.bready)
         begin
            bValid_q <= 1'b0;
         end
      end
   end

   // Writable control and mask; the status words are read only.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         run_q <= `SSD_CTRL_RST;
         irqMask_q <= `SSD_MASK_RST;
      end
      else if (wrDo && wStrb_q[0])
      begin
         if (awAddr_q == `SSD_OFS_CTRL)
         begin
            run_q <= wData_q[`SSD_CTRL_RUN];
         end
         else if (awAddr_q == `SSD_OFS_IRQ_MASK)
         begin
            irqMask_q <= wData_q[`SSD_NUM_EV-1:0];
         end
      end
   end

   // Returns read data one cycle after the address is taken.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0;
         rResp_q <= `SSD_BRESP_OK;
      end
      else if (arTake)
      begin
         rValid_q <= 1'b1;
         rResp_q <= `SSD_BRESP_OK;
         if (axiReq.araddr == `SSD_OFS_CTRL)
            rData_q <= {31'h0, run_q};
         else if (axiReq.araddr == `SSD_OFS_STATUS)
            rData_q <= {20'h0, pulseNo_q, code, state_q, diagOut, safetyOutB, safetyOutA, run_q};
         else if (axiReq.araddr == `SSD_OFS_IRQ_STAT)
            rData_q <= {28'h0, irqStat_q};
         else if (axiReq.araddr == `SSD_OFS_IRQ_MASK)
            rData_q <= {28'h0, irqMask_q};
         else
         begin
            rData_q <= 32'h0;
            rResp_q <= `SSD_BRESP_ERR;
         end
      end
      else if (rValid_q && axiReq.rready)
      begin
         rValid_q <= 1'b0;
      end
   end

   // Ready terms are combinational and drop while the matching side is held.
   always_comb
   begin
      axiRsp.awready = ~awHeld_q;
      axiRsp.wready = ~wHeld_q;
      axiRsp.bvalid = bValid_q;
      axiRsp.bresp = bResp_q;
      axiRsp.arready = ~rValid_q;
      axiRsp.rvalid = rValid_q;
      axiRsp.rdata = rData_q;
      axiRsp.rresp = rResp_q;
   end

endmodule

// [sim/ssd_chain_partner.sv]
// Holds a model of the upstream chained sensor and of the downstream safety controller.
// Assumes the bench commands the upstream channels and reads the controller verdict.
module ssd_chain_partner #(
   parameter int unsigned DROP_CYC = 20
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic upA,
   input wire logic upB,
   input wire logic outA,
   input wire logic outB,
   output logic inA,
   output logic inB,
   output logic guardOk
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned lowCnt_q; // Cycles since both outputs were last high.

   // Upstream outputs feed our inputs a cycle late; an end device holds both at supply.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         inA <= 1'b1;
         inB <= 1'b1;
      end
      else
      begin
         inA <= upA;
         inB <= upB;
      end
   end

   // The controller forgives short self-test dropouts of the output pair.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         lowCnt_q <= DROP_CYC + 1;
      else if (outA && outB)
         lowCnt_q <= 0;
      else if (lowCnt_q <= DROP_CYC)
         lowCnt_q <= lowCnt_q + 1;
   end
   assign guardOk = (lowCnt_q <= DROP_CYC);
endmodule

// [sim/ssd_core_properties.sv]
// Holds the concurrent checks on the ports of the sensor diagnostics core.
// Assumes a bind to ssd_core, with the limit blink half-period shortened to four cycles.
module ssd_core_properties #(
   parameter int unsigned DIAG_CYC = 40,
   parameter int unsigned SAFE_CYC = 120
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire ssd_pkg::ssd_axi_req_t axiReq,
   input wire ssd_pkg::ssd_axi_rsp_t axiRsp,
   input wire logic actPresent,
   input wire logic actLimit,
   input wire ssd_pkg::ssd_faults_t faults,
   input wire logic safetyInA,
   input wire logic safetyInB,
   input wire logic safetyOutA,
   input wire logic safetyOutB,
   input wire logic diagOut,
   input wire ssd_pkg::ssd_led_t led,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssd_pkg::*;

   // ----------------------------------------
   // Fault age
   // ----------------------------------------
   logic anyFault; // High while any fault input is high.
   logic warnFault; // High for a fault of the warning class only.
   int unsigned faultAge_q; // Cycles since the current fault began.
   assign anyFault = |faults;
   assign warnFault = anyFault && !faults.internalErr;

   // Counts fault cycles and restarts when all faults go away.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         faultAge_q <= 0;
      else
         faultAge_q <= anyFault ? faultAge_q + 1 : 0;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_outs_paired: assert property (safetyOutA == safetyOutB)
      else $error("safety outputs differ");
   a_chain_gate: assert property (!(safetyInA && safetyInB && actPresent) |=> !safetyOutA)
      else $error("output on without chain input or actuator");
   a_hard_cut: assert property (faults.internalErr |=> !safetyOutA)
      else $error("hard failure left outputs on");
   a_idle_green: assert property ((!actPresent && !anyFault && !$past(anyFault))
      |=> led.green && !diagOut && !safetyOutA) else $error("idle state wrong");
   a_act_yellow: assert property ((actPresent && !actLimit && !anyFault && !$past(anyFault))
      |=> led.yellow && diagOut) else $error("actuated state wrong");
   a_fault_red: assert property ($rose(anyFault) |-> ##2 led.red)
      else $error("fault not shown red");
   a_diag_drop: assert property ((anyFault && faultAge_q > DIAG_CYC) |=> !diagOut)
      else $error("diagnostic not dropped after delay");
   a_diag_hold: assert property ((anyFault && actPresent && faultAge_q + 2 < DIAG_CYC)
      |=> diagOut) else $error("diagnostic dropped early");
   a_safe_drop: assert property ((warnFault && faultAge_q > SAFE_CYC) |=> !safetyOutA)
      else $error("warning fault left outputs on");
   a_limit_pulse: assert property ((actPresent && actLimit && !anyFault) [*6]
      |-> diagOut != $past(diagOut, 4)) else $error("limit range blink missing");

   c_limit: cover property ((actPresent && actLimit) [*6]);
   c_hard: cover property (faults.internalErr && !safetyOutA && led.red);
   c_warn_drop: cover property (warnFault && faultAge_q > SAFE_CYC);
endmodule

// [sim/ssd_core_tb.sv]
// Holds the self-checking bench of the sensor diagnostics core.
// Assumes the package, the core, the checker and the chain partner are compiled first.
module ssd_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ssd_pkg::*;

   // Shortened counts keep the run brief; every expectation but the limit blink, which follows LIMIT_CYC of 4, derives from them.
   localparam int unsigned DIAG = 40;
   localparam int unsigned SAFE = 120;
   localparam int unsigned ANA = 8;
   localparam int unsigned FLASH = 3;
   localparam int unsigned GAP = 6;
   localparam logic [7:0] FBITS [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
   localparam int CODES [7] = '{1, 2, 3, 1, 2, 4, 5};

   logic mclk = 1'b0;
   logic rstn = 1'b0;
   ssd_axi_req_t req = '0;
   ssd_axi_rsp_t rsp;
   logic actPresent = 1'b0;
   logic actLimit = 1'b0;
   ssd_faults_t faults = '0;
   logic upA = 1'b1;
   logic upB = 1'b1;
   logic inA, inB, outA, outB, diagOut, irq, guardOk, prev;
   ssd_led_t led;
   int mismatches = 0;
   int total_checks = 0;
   int n, y;
   logic [31:0] rd;
   logic [1:0] resp;

   always #50 mclk = ~mclk;

   ssd_core #(.DIAG_CYC(DIAG), .SAFE_CYC(SAFE), .LIMIT_CYC(4), .ANALYSE_CYC(ANA),
      .FLASH_CYC(FLASH), .GAP_CYC(GAP)) u_ssd_core (.mclk(mclk), .rstn(rstn),
      .axiReq(req), .axiRsp(rsp), .actPresent(actPresent), .actLimit(actLimit),
      .faults(faults), .safetyInA(inA), .safetyInB(inB), .safetyOutA(outA),
      .safetyOutB(outB), .diagOut(diagOut), .led(led), .irq(irq));
   ssd_chain_partner u_ssd_chain_partner (.mclk(mclk), .rstn(rstn), .upA(upA), .upB(upB),
      .outA(outA), .outB(outB), .inA(inA), .inB(inB), .guardOk(guardOk));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic tick(input int c);
      repeat (c) @(posedge mclk);
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Offers address and data together and holds each until it is taken.
   task automatic axWrite(input logic [3:0] a, input logic [31:0] d);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
      end
      while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
   endtask

   task automatic axRead(input logic [3:0] a);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (rsp.arready)
            req.arvalid <= 1'b0;
      end
      while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      resp = rsp.rresp;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      tick(12);
      rstn <= 1'b1;
      tick(1);
      axRead(`SSD_OFS_CTRL);
      chkWord(rd, 32'h1, "ctrl reset");
      axRead(`SSD_OFS_IRQ_MASK);
      chkWord(rd, 32'h0, "mask reset");
      chkWord({led, diagOut, outA}, 32'h10, "idle");
      axRead(4'h2);
      chkWord({rd[29:0], resp}, 32'h2, "unmapped read");
      axWrite(`SSD_OFS_STATUS, 32'h0);
      chkWord({30'h0, resp}, 32'h0, "status write ignored");
      actPresent <= 1'b1;
      tick(3);
      chkWord({led, diagOut, outA, outB}, 32'h17, "actuated");
      chkWord({31'h0, guardOk}, 32'h1, "controller sees closed guard");
      axRead(`SSD_OFS_STATUS);
      chkWord(rd & 32'h3F, 32'hF, "status ok");
      upB <= 1'b0;
      tick(4);
      chkWord({outA, outB}, 32'h0, "chain input low");
      upB <= 1'b1;
      axWrite(`SSD_OFS_CTRL, 32'h0);
      tick(3);
      chkWord({outA, outB}, 32'h0, "run cleared");
      axWrite(`SSD_OFS_CTRL, 32'h1);
      axWrite(`SSD_OFS_IRQ_MASK, 32'h4);
      axRead(`SSD_OFS_IRQ_STAT);
      actLimit <= 1'b1;
      tick(2);
      n = 0;
      y = 0;
      repeat (16)
      begin
         @(posedge mclk);
         n += (diagOut === 1'b1);
         y += (led.yellow === 1'b1 && outA === 1'b1);
      end
      chkWord(n, 8, "limit diag blink");
      chkWord(y, 8, "limit yellow blink, outputs on");
      chkWord({31'h0, irq}, 32'h1, "limit event raised");
      axRead(`SSD_OFS_IRQ_STAT);
      chkWord({31'h0, rd[`SSD_EV_LIMIT]}, 32'h1, "limit event bit");
      chkWord({31'h0, irq}, 32'h0, "event cleared by read");
      actLimit <= 1'b0;
      axWrite(`SSD_OFS_IRQ_MASK, 32'h0);
      actLimit <= 1'b1;
      tick(3);
      chkWord({31'h0, irq}, 32'h0, "masked event quiet");
      actLimit <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         faults <= FBITS[i];
         tick(3);
         chkWord({31'h0, led.red}, 32'h1, "analysis red");
         tick(ANA + 1);
         n = 0;
         prev = led.red;
         repeat (CODES[i] * 2 * FLASH + GAP)
         begin
            @(posedge mclk);
            n += (led.red === 1'b1 && prev === 1'b0);
            prev = led.red;
         end
         chkWord(n, CODES[i], "flash code");
         chkWord({31'h0, outA}, 32'h1, "warning keeps outputs");
         faults <= '0;
         tick(4);
      end
      axWrite(`SSD_OFS_IRQ_MASK, 32'h2);
      axRead(`SSD_OFS_IRQ_STAT);
      faults <= 8'h04;
      tick(DIAG - 10);
      chkWord({diagOut, outA}, 32'h3, "before diag delay");
      tick(20);
      chkWord({diagOut, outA}, 32'h1, "after diag delay");
      tick(SAFE - DIAG);
      chkWord({outA, outB, irq}, 32'h1, "warning drops outputs");
      axRead(`SSD_OFS_IRQ_STAT);
      chkWord({rd[30:0], irq}, 32'h6, "fault and drop events read, cleared");
      faults <= '0;
      tick(4);
      faults <= 8'h01;
      tick(2);
      chkWord({outA, outB}, 32'h0, "hard cut");
      n = 0;
      repeat (20)
      begin
         @(posedge mclk);
         n += (led.red === 1'b1);
      end
      chkWord({n[30:0], diagOut}, {31'd20, 1'b1}, "steady red, diag held");
      tick(DIAG);
      chkWord({31'h0, diagOut}, 32'h0, "hard diag dropped");
      faults <= '0;
      tick(4);
      chkWord({led.yellow, outA}, 32'h3, "recovered");
      conclude();
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      tick(5000);
      mismatches++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      conclude();
   end
endmodule

bind ssd_core ssd_core_properties #(.DIAG_CYC(DIAG_CYC), .SAFE_CYC(SAFE_CYC))
   u_ssd_core_properties (.mclk(mclk), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp),
   .actPresent(actPresent), .actLimit(actLimit), .faults(faults), .safetyInA(safetyInA),
   .safetyInB(safetyInB), .safetyOutA(safetyOutA), .safetyOutB(safetyOutB),
   .diagOut(diagOut), .led(led), .irq(irq));
